//--- src/scp_edge.sv
// falling edge detector for the shared timing line, registered output
// assumes the line level is synchronous to mclk
`timescale 1ns/10ps
module scp_edge (
    // clock and reset
    input  wire logic mclk,
    input  wire logic rst,
    // line
    input  wire logic line_in,
    output logic      fall
);
    typedef struct packed {
        logic prev;
        logic fall;
    } scp_edge_st_t;

    scp_edge_st_t cur_ff;
    scp_edge_st_t nxt_ff;

    // rising edges produce nothing, only high-to-low counts
    always_comb begin
        nxt_ff      = cur_ff;
        nxt_ff.prev = line_in;
        nxt_ff.fall = cur_ff.prev & ~line_in;
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            cur_ff <= '{prev: 1'b1, fall: 1'b0};
        end else begin
            cur_ff <= nxt_ff;
        end
    end

    assign fall = cur_ff.fall;
endmodule

//--- src/scp_pkg.sv
// constants, register map and carrier types for the switching clock sync block
// assumes a 250 MHz mclk and a plain strobe register port
// Function
// - lock phase to falling edges of timing line
// - phase offset from low three config bits
// - edge comparator, fixed phase, no harmonic lock
// - guaranteed lock from 85 kHz to 500 kHz
// - lock loss sets status bit 4, alert
// - writing one clears the lock loss bit
// - masked lock loss recorded but no alert
// - no line signal: run at programmed frequency
// - external-only with no line: lowest frequency
// - driving while line active: pad bit 10 low
// - drive pulls line low 500 ns per period, none while locked
package scp_pkg;

    // register offsets
    localparam logic [7:0] ADDR_PHASE_CFG = 8'h00; // converter_phase_config
    localparam logic [7:0] ADDR_FREQ_CFG  = 8'h04; // period setting, clock cycles
    localparam logic [7:0] ADDR_CTRL      = 8'h08; // line drive, external-only
    localparam logic [7:0] ADDR_VSTATUS   = 8'h0C; // vendor_status_word
    localparam logic [7:0] ADDR_MASK      = 8'h10; // alert_mask_setting
    localparam logic [7:0] ADDR_PADS      = 8'h14; // pad_status_word
    localparam logic [7:0] ADDR_PERIOD    = 8'h18; // measured line period

    // field positions
    localparam int LOCK_LOSS_BIT = 4;
    localparam int LINE_CONF_BIT = 10;
    localparam int CTRL_DRIVE_BIT = 0;
    localparam int CTRL_EXTONLY_BIT = 1;
    localparam int PHASE_W = 3;

    // timing
    localparam int CLK_MHZ       = 250;
    localparam int PULSE_NS      = 500;
    localparam int PULSE_CYC     = (PULSE_NS * CLK_MHZ) / 1000;
    localparam int FMIN_KHZ      = 85;
    localparam int FMAX_KHZ      = 500;
    localparam int PER_MAX_CYC   = (CLK_MHZ * 1000) / FMIN_KHZ;
    localparam int PER_MIN_CYC   = (CLK_MHZ * 1000) / FMAX_KHZ;
    localparam int LOCK_TOL_CYC  = 8;
    localparam int LINE_TMO_CYC  = 2 * PER_MAX_CYC;

    // reset values
    localparam logic [31:0] FREQ_RST  = 32'h0000_03E8; // 250 kHz
    localparam logic [31:0] PHASE_RST = 32'h0000_0000;
    localparam logic [31:0] CTRL_RST  = 32'h0000_0001;
    localparam logic [31:0] MASK_RST  = 32'h0000_0000;
    localparam logic [15:0] PER_SLOW  = 16'(PER_MAX_CYC);

    typedef struct packed {
        logic [7:0]  addr;
        logic [31:0] wdata;
        logic        wr;
        logic        rd;
    } scp_bus_t;

endpackage

//--- src/scp_top.sv
// switching clock synchronizer: digital pll on the shared timing line
// assumes strobe register port, line pulled up externally
//
// The implementer's own choices: the address map and the plain strobed port.
`timescale 1ns/10ps
module scp_top (
    // clock and reset
    input  wire logic            mclk,
    input  wire logic            rst,
    // register port
    input  wire scp_pkg::scp_bus_t bus,
    output logic [31:0]          rdata,
    // shared timing line, open drain
    input  wire logic            line_in,
    output logic                 line_out,
    output logic                 line_oe,
    // converter clock and alert
    output logic                 conv_clk,
    output logic                 alert_n,
    output logic                 irq
);
    import scp_pkg::*;

    typedef enum logic [1:0] {S_FREE, S_TRACK, S_LOCKED} scp_mode_t;

    typedef struct packed {
        logic [PHASE_W-1:0] phase;
        logic [15:0]        freq;
        logic               drive;
        logic               extonly;
        logic               loss;
        logic               mask;
        logic               mask_conf;
        logic               conf;
        logic [15:0]        meas;
        logic [15:0]        per_cnt;
        logic [15:0]        line_cnt;
        logic [15:0]        osc_cnt;
        logic [15:0]        osc_per;
        logic [15:0]        off_cnt;
        logic               off_run;
        logic [9:0]         pul_cnt;
        logic               conv;
        logic               line_drv;
        logic               alert_n;
        logic               irq;
        logic [31:0]        rdata;
        scp_mode_t          mode;
    } scp_st_t;

    scp_st_t cur_ff;
    scp_st_t nxt_ff;
    logic    fall;

    scp_edge u_edge (
        .mclk    (mclk),
        .rst     (rst),
        .line_in (line_in),
        .fall    (fall)
    );

    // absolute difference used by lock test
    function automatic logic [15:0] absdiff(input logic [15:0] a, input logic [15:0] b);
        absdiff = (a > b) ? 16'(a - b) : 16'(b - a);
    endfunction

    // offset in cycles from phase code: eighths of the period
    function automatic logic [15:0] phase_off(input logic [15:0] per,
                                              input logic [PHASE_W-1:0] ph);
        logic [18:0] prod;
        prod      = 19'(per) * 19'(ph);
        phase_off = 16'(prod >> PHASE_W);
    endfunction

    logic in_range;
    logic line_seen;
    assign line_seen = fall & ~cur_ff.line_drv;

    always_comb begin
        nxt_ff   = cur_ff;
        in_range = (cur_ff.per_cnt >= 16'(PER_MIN_CYC)) && (cur_ff.per_cnt <= 16'(PER_MAX_CYC));

        // register writes
        if (bus.wr) begin
            if (bus.addr == ADDR_PHASE_CFG) begin
                nxt_ff.phase = bus.wdata[PHASE_W-1:0];
            end else if (bus.addr == ADDR_FREQ_CFG) begin
                nxt_ff.freq = bus.wdata[15:0];
            end else if (bus.addr == ADDR_CTRL) begin
                nxt_ff.drive   = bus.wdata[CTRL_DRIVE_BIT];
                nxt_ff.extonly = bus.wdata[CTRL_EXTONLY_BIT];
            end else if (bus.addr == ADDR_VSTATUS) begin
                if (bus.wdata[LOCK_LOSS_BIT]) begin
                    nxt_ff.loss = 1'b0;
                end
                if (bus.wdata[LINE_CONF_BIT]) begin
                    nxt_ff.conf = 1'b0;
                end
            end else if (bus.addr == ADDR_MASK) begin
                nxt_ff.mask      = bus.wdata[LOCK_LOSS_BIT];
                nxt_ff.mask_conf = bus.wdata[LINE_CONF_BIT];
            end
        end

        // read data, one cycle later
        nxt_ff.rdata = 32'h0000_0000;
        if (bus.rd) begin
            if (bus.addr == ADDR_PHASE_CFG) begin
                nxt_ff.rdata = {29'h0, cur_ff.phase};
            end else if (bus.addr == ADDR_FREQ_CFG) begin
                nxt_ff.rdata = {16'h0, cur_ff.freq};
            end else if (bus.addr == ADDR_CTRL) begin
                nxt_ff.rdata = {30'h0, cur_ff.extonly, cur_ff.drive};
            end else if (bus.addr == ADDR_VSTATUS) begin
                nxt_ff.rdata = {21'h0, cur_ff.conf, 5'h0, cur_ff.loss, 4'h0};
            end else if (bus.addr == ADDR_MASK) begin
                nxt_ff.rdata = {21'h0, cur_ff.mask_conf, 5'h0, cur_ff.mask, 4'h0};
            end else if (bus.addr == ADDR_PADS) begin
                // active low: conflict shows as zero
                nxt_ff.rdata = {21'h0, ~cur_ff.conf, 10'h0};
            end else if (bus.addr == ADDR_PERIOD) begin
                nxt_ff.rdata = {16'h0, cur_ff.meas};
            end
        end

        // period measurement between foreign falling edges
        if (cur_ff.per_cnt != 16'hFFFF) begin
            nxt_ff.per_cnt = 16'(cur_ff.per_cnt + 16'd1);
        end
        if (cur_ff.line_cnt != 16'hFFFF) begin
            nxt_ff.line_cnt = 16'(cur_ff.line_cnt + 16'd1);
        end

        // pll state: phase comparison only on falling edges
        case (cur_ff.mode)
            S_FREE: begin
                if (line_seen) begin
                    nxt_ff.mode     = S_TRACK;
                    nxt_ff.per_cnt  = 16'd1;
                    nxt_ff.line_cnt = 16'd0;
                end
            end
            S_TRACK: begin
                if (line_seen) begin
                    nxt_ff.per_cnt  = 16'd1;
                    nxt_ff.line_cnt = 16'd0;
                    // only a period inside the guaranteed span is accepted
                    if (in_range) begin
                        nxt_ff.meas    = cur_ff.per_cnt;
                        nxt_ff.osc_per = cur_ff.per_cnt;
                        nxt_ff.mode    = S_LOCKED;
                    end
                end else if (cur_ff.line_cnt >= 16'(LINE_TMO_CYC)) begin
                    nxt_ff.mode = S_FREE;
                end
            end
            default: begin
                if (line_seen) begin
                    nxt_ff.per_cnt  = 16'd1;
                    nxt_ff.line_cnt = 16'd0;
                    nxt_ff.meas     = cur_ff.per_cnt;
                    // compare to whole period: a harmonic never passes
                    if (!in_range ||
                        absdiff(cur_ff.per_cnt, cur_ff.osc_per) > 16'(LOCK_TOL_CYC)) begin
                        nxt_ff.loss = 1'b1;
                        nxt_ff.mode = S_TRACK;
                    end else begin
                        nxt_ff.osc_per = cur_ff.per_cnt;
                    end
                end else if (cur_ff.line_cnt >= 16'(LINE_TMO_CYC)) begin
                    nxt_ff.loss = 1'b1;
                    nxt_ff.mode = S_FREE;
                end
            end
        endcase

        // free-run period: programmed, or slowest when external-only
        // next state decides, so a fresh lock keeps its measured period
        if (nxt_ff.mode != S_LOCKED) begin
            nxt_ff.osc_per = nxt_ff.extonly ? PER_SLOW : nxt_ff.freq;
        end

        // converter clock: offset start after each falling edge when locked
        nxt_ff.osc_cnt = 16'(cur_ff.osc_cnt + 16'd1);
        if (cur_ff.mode == S_LOCKED && line_seen) begin
            nxt_ff.off_cnt = phase_off(cur_ff.osc_per, cur_ff.phase);
            nxt_ff.off_run = 1'b1;
        end else if (cur_ff.off_run) begin
            if (cur_ff.off_cnt == 16'd0) begin
                nxt_ff.osc_cnt = 16'd0;
                nxt_ff.off_run = 1'b0;
            end else begin
                nxt_ff.off_cnt = 16'(cur_ff.off_cnt - 16'd1);
            end
        end else if (cur_ff.osc_cnt >= 16'(cur_ff.osc_per - 16'd1)) begin
            nxt_ff.osc_cnt = 16'd0;
        end
        nxt_ff.conv = (nxt_ff.osc_cnt < {1'b0, cur_ff.osc_per[15:1]});

        // line drive: low pulse at start of own period
        if (cur_ff.drive && cur_ff.mode != S_LOCKED && cur_ff.osc_cnt == 16'd0) begin
            nxt_ff.pul_cnt = 10'(PULSE_CYC);
        end else if (cur_ff.pul_cnt != 10'd0) begin
            nxt_ff.pul_cnt = 10'(cur_ff.pul_cnt - 10'd1);
        end
        nxt_ff.line_drv = (nxt_ff.pul_cnt != 10'd0);

        // a foreign edge while configured to drive is a conflict; set wins
        if (cur_ff.drive && line_seen) begin
            nxt_ff.conf = 1'b1;
        end

        // alert follows the sticky unmasked bit
        nxt_ff.alert_n = ~(nxt_ff.loss & ~nxt_ff.mask);
        // interrupt: any unmasked sticky status bit, conflict included
        nxt_ff.irq     = (nxt_ff.loss & ~nxt_ff.mask) | (nxt_ff.conf & ~nxt_ff.mask_conf);
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            cur_ff         <= '0;
            cur_ff.freq    <= FREQ_RST[15:0];
            cur_ff.drive   <= CTRL_RST[CTRL_DRIVE_BIT];
            cur_ff.osc_per <= FREQ_RST[15:0];
            cur_ff.alert_n <= 1'b1;
            cur_ff.mode    <= S_FREE;
        end else begin
            cur_ff <= nxt_ff;
        end
    end

    // outputs, all from flops but line_out, tied low
    assign rdata    = cur_ff.rdata;
    assign line_out = 1'b0;
    assign line_oe  = cur_ff.line_drv;
    assign conv_clk = cur_ff.conv;
    assign alert_n  = cur_ff.alert_n;
    assign irq      = cur_ff.irq;

    // assertions
    // first two are same-cycle checks: a mask or clear write moves flag and alert on one edge
    property p_alert_follow;
        @(posedge mclk) disable iff (rst) (cur_ff.loss && !cur_ff.mask) |-> !alert_n;
    endproperty
    a_alert_follow: assert property (p_alert_follow) else $error("alert not low");

    property p_mask;
        @(posedge mclk) disable iff (rst) cur_ff.mask |-> alert_n;
    endproperty
    a_mask: assert property (p_mask) else $error("masked alert driven");

    property p_clear;
        @(posedge mclk) disable iff (rst)
        (bus.wr && bus.addr == ADDR_VSTATUS && bus.wdata[LOCK_LOSS_BIT] &&
         !(cur_ff.mode == S_LOCKED && (line_seen || cur_ff.line_cnt >= 16'(LINE_TMO_CYC))))
        |=> !cur_ff.loss;
    endproperty
    a_clear: assert property (p_clear) else $error("loss not cleared");

    property p_sticky;
        @(posedge mclk) disable iff (rst)
        (cur_ff.loss && !(bus.wr && bus.addr == ADDR_VSTATUS)) |=> cur_ff.loss;
    endproperty
    a_sticky: assert property (p_sticky) else $error("loss bit dropped");

    sequence s_pulse_start;
        cur_ff.drive && cur_ff.mode != S_LOCKED && cur_ff.osc_cnt == 16'd0;
    endsequence
    property p_pulse;
        @(posedge mclk) disable iff (rst) s_pulse_start |=> line_oe [*8];
    endproperty
    a_pulse: assert property (p_pulse) else $error("line pulse short");

    property p_nodrive;
        @(posedge mclk) disable iff (rst) !cur_ff.drive && !line_oe |=> !line_oe;
    endproperty
    a_nodrive: assert property (p_nodrive) else $error("line driven while off");

    property p_conf;
        @(posedge mclk) disable iff (rst) (cur_ff.drive && line_seen) |=> cur_ff.conf;
    endproperty
    a_conf: assert property (p_conf) else $error("conflict not flagged");

    property p_slow;
        @(posedge mclk) disable iff (rst)
        (cur_ff.mode != S_LOCKED && cur_ff.extonly) |-> cur_ff.osc_per == PER_SLOW;
    endproperty
    a_slow: assert property (p_slow) else $error("external-only not slowest");

    property p_nominal;
        @(posedge mclk) disable iff (rst)
        (cur_ff.mode == S_FREE && !cur_ff.extonly) |-> cur_ff.osc_per == cur_ff.freq;
    endproperty
    a_nominal: assert property (p_nominal) else $error("free run not nominal");

    // a read answers the flags as they stood at the strobe
    property p_rd_loss;
        @(posedge mclk) disable iff (rst)
        (bus.rd && bus.addr == ADDR_VSTATUS) |=> rdata[LOCK_LOSS_BIT] == $past(cur_ff.loss);
    endproperty
    a_rd_loss: assert property (p_rd_loss) else $error("status read wrong");

    property p_rd_pads;
        @(posedge mclk) disable iff (rst)
        (bus.rd && bus.addr == ADDR_PADS) |=> rdata[LINE_CONF_BIT] == !$past(cur_ff.conf);
    endproperty
    a_rd_pads: assert property (p_rd_pads) else $error("pad read wrong");

    // a second in-range edge while tracking closes the loop
    property p_acquire;
        @(posedge mclk) disable iff (rst)
        (cur_ff.mode == S_TRACK && line_seen && in_range) |=> cur_ff.mode == S_LOCKED;
    endproperty
    a_acquire: assert property (p_acquire) else $error("in-range edge not locked");

    // between falling edges, until the line timeout, a locked loop keeps its state
    property p_hold;
        @(posedge mclk) disable iff (rst)
        (cur_ff.mode == S_LOCKED && !line_seen && cur_ff.line_cnt < 16'(LINE_TMO_CYC))
        |=> cur_ff.mode == S_LOCKED;
    endproperty
    a_hold: assert property (p_hold) else $error("lock left without edge");

    sequence s_locked_edge;
        cur_ff.mode == S_LOCKED && line_seen;
    endsequence
    property p_resync;
        @(posedge mclk) disable iff (rst) s_locked_edge |=> cur_ff.off_run;
    endproperty
    a_resync: assert property (p_resync) else $error("phase offset not started");

    // a period off by more than the tolerance drops lock and records it
    property p_slip;
        @(posedge mclk) disable iff (rst)
        (cur_ff.mode == S_LOCKED && line_seen &&
         absdiff(cur_ff.per_cnt, cur_ff.osc_per) > 16'(LOCK_TOL_CYC))
        |=> cur_ff.loss && cur_ff.mode == S_TRACK;
    endproperty
    a_slip: assert property (p_slip) else $error("slip not flagged");

    // a silent line while locked falls back to free running, fault kept
    property p_silent;
        @(posedge mclk) disable iff (rst)
        (cur_ff.mode == S_LOCKED && !line_seen && cur_ff.line_cnt >= 16'(LINE_TMO_CYC))
        |=> cur_ff.loss && cur_ff.mode == S_FREE;
    endproperty
    a_silent: assert property (p_silent) else $error("silent line not flagged");

    property p_irq;
        @(posedge mclk) disable iff (rst) (cur_ff.conf && !cur_ff.mask_conf) |-> irq;
    endproperty
    a_irq: assert property (p_irq) else $error("conflict interrupt missing");
endmodule

//--- verification/scp_peer.sv
// peer converter controller that may own the shared timing line
// assumes mclk domain and an external pull-up on the open drain line
`timescale 1ns/10ps
module scp_peer (
    // clock and reset
    input  wire logic        mclk,
    input  wire logic        rst,
    // control from the bench
    input  wire logic        en,
    input  wire logic [15:0] per,
    // pull-down enable onto the line
    output logic             oe
);
    import scp_pkg::*;

    logic [15:0] cnt_ff;

    // only the elected owner pulls the line; disabled peers release it to the pull-up
    always_ff @(posedge mclk) begin
        if (rst || !en) begin
            cnt_ff <= 16'h0000;
            oe     <= 1'b0;
        end else begin
            cnt_ff <= (cnt_ff >= per - 16'h0001) ? 16'h0000 : cnt_ff + 16'h0001;
            oe     <= (cnt_ff < 16'(PULSE_CYC));
        end
    end
endmodule

//--- verification/switching_clock_sync_pll_test.sv
// self-checking bench for the switching clock synchronizer
// assumes scp_peer is the only other party on the shared line
`timescale 1ns/10ps
module switching_clock_sync_pll_test;
    import scp_pkg::*;

    localparam int TMO_CYC = 90000;

    logic        mclk = 1'b0;
    logic        rst = 1'b1;
    scp_bus_t    bus = '0;
    logic [31:0] rdata;
    logic        line_in;
    logic        line_out;
    logic        line_oe;
    logic        conv_clk;
    logic        alert_n;
    logic        irq;
    logic        peer_en = 1'b0;
    logic [15:0] peer_per = 16'h0000;
    logic        peer_oe;
    logic [31:0] r = 32'h0001_3C15;
    logic [31:0] v;
    logic        cc_q = 1'b0;
    logic        oe_q = 1'b0;
    logic        li_q = 1'b1;
    int          n_fail = 0;
    int          tests_run = 0;
    int          cyc = 0;
    int          cc_cnt = 0;
    int          oe_cnt = 0;
    int          w_cnt = 0;
    int          f_cnt = 0;
    int          clk_per = 0;
    int          oe_per = 0;
    int          oe_w = 0;
    int          fall_dly = 0;

    // wired-and of both pull-downs against the pull-up
    assign line_in = !((line_oe && !line_out) || peer_oe);

    scp_top scp_top_i (
        .mclk(mclk), .rst(rst), .bus(bus), .rdata(rdata), .line_in(line_in),
        .line_out(line_out), .line_oe(line_oe), .conv_clk(conv_clk),
        .alert_n(alert_n), .irq(irq)
    );

    scp_peer scp_peer_i (
        .mclk(mclk), .rst(rst), .en(peer_en), .per(peer_per), .oe(peer_oe)
    );

    initial begin
        forever #2 mclk = ~mclk;
    end

    // edge-to-edge measurements, so expectations never need the design's internals
    always @(posedge mclk) begin
        cc_q   <= conv_clk;
        oe_q   <= line_oe;
        li_q   <= line_in;
        cc_cnt <= (conv_clk && !cc_q) ? 1 : cc_cnt + 1;
        oe_cnt <= (line_oe && !oe_q) ? 1 : oe_cnt + 1;
        f_cnt  <= (li_q && !line_in) ? 1 : f_cnt + 1;
        w_cnt  <= line_oe ? w_cnt + 1 : 0;
        if (conv_clk && !cc_q) clk_per <= cc_cnt;
        if (conv_clk && !cc_q) fall_dly <= f_cnt;
        if (line_oe && !oe_q) oe_per <= oe_cnt;
        if (oe_q && !line_oe) oe_w <= w_cnt;
    end

    // hang guard: counts as a mismatch and closes the run
    always @(posedge mclk) begin
        cyc <= cyc + 1;
        if (cyc == TMO_CYC) begin
            n_fail++;
            complete_run();
        end
    end

    function automatic logic [31:0] lfsr_next(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge mclk);
        bus.wr    <= 1'b1;
        bus.addr  <= a;
        bus.wdata <= d;
        @(posedge mclk);
        bus.wr <= 1'b0;
    endtask

    // read data stands only in the cycle after the strobe
    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        @(posedge mclk);
        bus.rd   <= 1'b1;
        bus.addr <= a;
        @(posedge mclk);
        bus.rd <= 1'b0;
        #1 d = rdata;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            n_fail++;
            $display("BAD %0t value %h expected %h", $time, got, exp);
        end
    endtask

    task automatic near(input int got, input int exp, input int tol);
        tests_run++;
        if (got < exp - tol || got > exp + tol) begin
            n_fail++;
            $display("BAD %0t count %0d expected %0d", $time, got, exp);
        end
    endtask

    task automatic complete_run();
        if (n_fail == 0 && tests_run > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    initial begin
        int f;
        int p;
        int d0;
        repeat (5) @(posedge mclk);
        rst <= 1'b0;
        // reset values, unmapped read, idle flags
        rd(ADDR_PHASE_CFG, v);
        chk(v, PHASE_RST);
        rd(ADDR_FREQ_CFG, v);
        chk(v, FREQ_RST);
        rd(ADDR_CTRL, v);
        chk(v, CTRL_RST);
        rd(ADDR_MASK, v);
        chk(v, MASK_RST);
        rd(8'h1C, v);
        chk(v, 32'h0000_0000);
        rd(ADDR_PADS, v);
        chk(v & 32'h0000_0400, 32'h0000_0400);
        chk({30'h0, alert_n, irq}, 32'h0000_0002);
        // free running owner at a random programmed period
        r = lfsr_next(r);
        f = 500 + int'(r % 1000);
        wr(ADDR_FREQ_CFG, 32'(f));
        repeat (3 * f) @(posedge mclk);
        near(clk_per, f, 1);
        near(oe_per, f, 1);
        near(oe_w, PULSE_CYC, 0);
        chk({31'h0, line_out}, 32'h0000_0000);
        // hand the line to the peer and track it
        r = lfsr_next(r);
        p = 500 + int'(r % 300);
        wr(ADDR_CTRL, 32'h0000_0000);
        peer_per <= 16'(p);
        peer_en  <= 1'b1;
        repeat (4 * p) @(posedge mclk);
        rd(ADDR_PERIOD, v);
        chk(v & 32'h0000_FFFF, 32'(p));
        // every phase code, offsets relative to code zero
        for (int ph = 0; ph < 8; ph++) begin
            wr(ADDR_PHASE_CFG, 32'(ph));
            repeat (4 * p) @(posedge mclk);
            near(clk_per, p, 2);
            if (ph == 0) d0 = fall_dly;
            near((fall_dly - d0 + p) % p, ph * p / 8, 2);
        end
        rd(ADDR_VSTATUS, v);
        chk(v & 32'h0000_0010, 32'h0000_0000);
        // period jump breaks lock; bit must outlive the relock
        peer_per <= 16'(p + 100);
        // loss, relock and one offset resync before a clean period shows
        repeat (6 * (p + 100)) @(posedge mclk);
        near(clk_per, p + 100, 2);
        rd(ADDR_VSTATUS, v);
        chk(v & 32'h0000_0010, 32'h0000_0010);
        chk({30'h0, alert_n, irq}, 32'h0000_0001);
        wr(ADDR_MASK, 32'h0000_0010);
        repeat (2) @(posedge mclk);
        chk({30'h0, alert_n, irq}, 32'h0000_0002);
        rd(ADDR_VSTATUS, v);
        chk(v & 32'h0000_0010, 32'h0000_0010);
        wr(ADDR_MASK, 32'h0000_0000);
        repeat (2) @(posedge mclk);
        chk({30'h0, alert_n, irq}, 32'h0000_0001);
        wr(ADDR_VSTATUS, 32'h0000_0010);
        repeat (2) @(posedge mclk);
        chk({30'h0, alert_n, irq}, 32'h0000_0002);
        rd(ADDR_VSTATUS, v);
        chk(v & 32'h0000_0010, 32'h0000_0000);
        // both owners enabled: conflict shows in pad and status words
        wr(ADDR_CTRL, 32'h0000_0001);
        repeat (3 * (p + 100)) @(posedge mclk);
        rd(ADDR_PADS, v);
        chk(v & 32'h0000_0400, 32'h0000_0000);
        rd(ADDR_VSTATUS, v);
        chk(v & 32'h0000_0400, 32'h0000_0400);
        chk({30'h0, alert_n, irq}, 32'h0000_0003);
        wr(ADDR_MASK, 32'h0000_0400);
        repeat (2) @(posedge mclk);
        chk({30'h0, alert_n, irq}, 32'h0000_0002);
        // external-only with a silent line falls to the slowest period
        peer_en <= 1'b0;
        wr(ADDR_CTRL, 32'h0000_0002);
        repeat (LINE_TMO_CYC + 3 * PER_MAX_CYC) @(posedge mclk);
        near(clk_per, PER_MAX_CYC, 2);
        // silent line recorded; one write clears both sticky bits
        rd(ADDR_VSTATUS, v);
        chk(v & 32'h0000_0410, 32'h0000_0410);
        chk({30'h0, alert_n, irq}, 32'h0000_0001);
        wr(ADDR_VSTATUS, 32'h0000_0410);
        rd(ADDR_VSTATUS, v);
        chk(v & 32'h0000_0410, 32'h0000_0000);
        rd(ADDR_PADS, v);
        chk(v & 32'h0000_0400, 32'h0000_0400);
        chk({30'h0, alert_n, irq}, 32'h0000_0002);
        complete_run();
    end
endmodule
